// ===== common/wfd_pkg.sv
// wfd_pkg: register map, field positions, reset values and constants of the wake frame detector
// assumes a 32-bit word-addressed register bus with byte addresses in the offsets below
package wfd_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
  localparam logic [7:0] ADDR_MID_OFS = 8'h04;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h08;
  localparam logic [7:0] WAKE_CTRL_OFS = 8'h0C;
  localparam logic [7:0] FILT_CFG_A_OFS = 8'h10;
  localparam logic [7:0] FILT_CFG_B_OFS = 8'h14;
  localparam logic [7:0] FILT_MASK0_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;
  localparam logic [7:0] IRQ_SRC_OFS = 8'h2C;
  localparam int MASK_WORDS = 4;
  // wake control and status fields
  localparam int EXACT_EN_BIT = 0;
  localparam int BCAST_EN_BIT = 1;
  localparam int PATTERN_EN_BIT = 2;
  localparam int FILTER_EN_BIT = 3;
  localparam int SEEN_LSB = 4;
  localparam int LIGHT1_SEL_LSB = 8;
  localparam int LIGHT2_SEL_LSB = 10;
  localparam int CONFIGURED_BIT = 12;
  localparam logic [1:0] LIGHT_SEL_PME = 2'h2;
  // filter config a fields
  localparam int OFFSET_LSB = 0;
  localparam int FILT_BCAST_BIT = 8;
  localparam int FILT_ANYMC_BIT = 9;
  localparam int FILT_ADDR_BIT = 10;
  localparam int FILT_TRIG_BIT = 11;
  localparam int FILT_ENABLE_BIT = 31;
  // interrupt wake bit in mask and source registers
  localparam int IRQ_WAKE_BIT = 8;
  // frame layout and pattern constants
  localparam logic [10:0] DA_LAST = 11'h005;
  localparam logic [10:0] SA_LAST = 11'h00B;
  localparam logic [10:0] POS_MAX = 11'h7FF;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [4:0] COPY_COUNT = 5'h10;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
  localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [10:0] MASK_SPAN = 11'h080;
  // reset values
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    WFD_SEARCH = 2'b00,
    WFD_COPIES = 2'b01,
    WFD_FOUND = 2'b11
  } wfd_pattern_type;
endpackage : wfd_pkg

// ===== rtl/wfd_crc16.sv
// wfd_crc16: byte-wide crc-16 accumulator of the programmable wake filter
// assumes byte strobes on the same clock as the caller
`timescale 1ns/1ps
`default_nettype none
module wfd_crc16 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // byte input
  input wire logic init,
  input wire logic upd,
  input wire logic [7:0] data,
  // result
  output logic [15:0] crc_r
);
  logic [15:0] base;
  logic [15:0] crc_nxt;
  logic [7:0] f;

  always_comb begin
    base = init ? wfd_pkg::CRC_INIT : crc_r;
    f[0] = base[15] ^ data[0];
    for (int i = 1; i < 8; i++) begin
      f[i] = base[15 - i] ^ f[i - 1] ^ data[i];
    end
    crc_nxt[15] = base[7] ^ f[7];
    crc_nxt[14:10] = base[6:2];
    crc_nxt[9] = base[1] ^ f[0];
    crc_nxt[8] = base[0] ^ f[1];
    for (int i = 2; i < 8; i++) begin
      crc_nxt[i] = f[7 - i] ^ f[9 - i];
    end
    crc_nxt[1] = f[6];
    crc_nxt[0] = f[7];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_r <= wfd_pkg::CRC_INIT;
    end else if (ce) begin
      if (upd) begin
        crc_r <= crc_nxt;
      end else if (init) begin
        crc_r <= wfd_pkg::CRC_INIT;
      end
    end
  end
endmodule : wfd_crc16
`default_nettype wire

// ===== rtl/wfd_top.sv
// wfd_top: wake frame detector with avalon-mm register slave
// assumes received bytes, frame markers and verdicts arrive on clk, one byte per strobe
//
// Notes on behaviour
// - exact-address enable: wake when destination equals the 48-bit station address.
// - every wake needs good frame check sequence and good length.
// - broadcast enable: wake on all-ones destination address.
// - any match sets interrupt, wake flag bit 8 and its kind's seen bit.
// - pattern frames must be unicast-to-station or broadcast; sync then sixteen copies.
// - broken copy run restarts the search for the sync run.
// - sync plus copies accepted anywhere after the source address.
// - filter crc-16 over mask-selected bytes compared to expected value.
// - mask bit j selects frame byte offset plus j, 128 bytes span.
// - address check: only the station address counts as specific match.
// - filter address verdict ors specific, any-multicast and broadcast.
// - unicast wakes if check off or address matches; broadcast if enabled.
// - multicast wakes if any-multicast on, or check on and address matches.
// - filter wake enable: each frame tested, seen bit set on pass.
// - power event output selectable on either status light pin.
// - crc starts all ones per frame, bitwise feedback, data bit 0 first.
// - pattern offset zero is the first destination address byte.
// - power event stays asserted until seen bits 7:4 are cleared.
// - wake configuration survives software reset.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module wfd_top #(
  parameter int MASK_BITS = 128
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic soft_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // received frame
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_fcs_ok,
  input wire logic rx_len_ok,
  // light sources from the link logic
  input wire logic light_one_src,
  input wire logic light_two_src,
  // pins
  output logic irq_out_n,
  output logic power_event_out_n,
  output logic status_light_one,
  output logic status_light_two
);
  logic [15:0] station_addr_low_r;
  logic [15:0] station_addr_mid_r;
  logic [15:0] station_addr_high_r;
  logic [12:0] wake_ctrl_status_r;
  logic [31:0] filter_config_a_r;
  logic [15:0] filter_config_b_r;
  logic [MASK_BITS-1:0] filter_byte_mask_r;
  logic irq_mask_r;
  logic irq_src_r;
  logic [47:0] station;
  logic acc_wr;
  logic [31:0] be_mask;
  logic [31:0] rd_nxt;
  // frame side
  logic [10:0] pos;
  logic [10:0] pos_r;
  logic in_frame_r;
  logic da_eq_r;
  logic da_bc_r;
  logic da_mc_r;
  logic [7:0] sta_byte;
  logic [2:0] idx_r;
  logic [2:0] sync_r;
  logic [4:0] copies_r;
  wfd_pkg::wfd_pattern_type pat_r;
  logic [10:0] rel;
  logic sel_byte;
  logic [15:0] crc_val;
  logic good_end;
  logic hit_exact;
  logic hit_bcast;
  logic hit_pat;
  logic hit_filt;
  logic filt_addr_ok;
  logic any_hit;
  logic [3:0] seen_clr;

  assign station = {station_addr_high_r, station_addr_mid_r, station_addr_low_r};
  assign acc_wr = avs_write && !avs_waitrequest;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = avs_byteenable[b] ? 8'hFF : 8'h00;
    end
  end

  // bus handshake: one wait cycle, data registered with waitrequest low
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= wfd_pkg::ZERO_RST;
    end else if (ce) begin
      if (avs_waitrequest && (avs_read || avs_write)) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_nxt : wfd_pkg::ZERO_RST;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // read mux; unmapped reads give zero
  always_comb begin
    rd_nxt = wfd_pkg::ZERO_RST;
    unique case (avs_address)
      wfd_pkg::ADDR_LOW_OFS: rd_nxt = {16'h0000, station_addr_low_r};
      wfd_pkg::ADDR_MID_OFS: rd_nxt = {16'h0000, station_addr_mid_r};
      wfd_pkg::ADDR_HIGH_OFS: rd_nxt = {16'h0000, station_addr_high_r};
      wfd_pkg::WAKE_CTRL_OFS: rd_nxt = {19'h00000, wake_ctrl_status_r};
      wfd_pkg::FILT_CFG_A_OFS: rd_nxt = filter_config_a_r;
      wfd_pkg::FILT_CFG_B_OFS: rd_nxt = {16'h0000, filter_config_b_r};
      wfd_pkg::IRQ_MASK_OFS: rd_nxt[wfd_pkg::IRQ_WAKE_BIT] = irq_mask_r;
      wfd_pkg::IRQ_SRC_OFS: rd_nxt[wfd_pkg::IRQ_WAKE_BIT] = irq_src_r;
      default: begin
        for (int w = 0; w < wfd_pkg::MASK_WORDS; w++) begin
          if (avs_address == wfd_pkg::FILT_MASK0_OFS + 8'(4 * w)) begin
            rd_nxt = filter_byte_mask_r[w*32 +: 32];
          end
        end
      end
    endcase
  end

  // station address; not touched by soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      station_addr_low_r <= 16'h0000;
      station_addr_mid_r <= 16'h0000;
      station_addr_high_r <= 16'h0000;
    end else if (ce && acc_wr) begin
      if (avs_address == wfd_pkg::ADDR_LOW_OFS) begin
        station_addr_low_r <= (station_addr_low_r & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
      end
      if (avs_address == wfd_pkg::ADDR_MID_OFS) begin
        station_addr_mid_r <= (station_addr_mid_r & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
      end
      if (avs_address == wfd_pkg::ADDR_HIGH_OFS) begin
        station_addr_high_r <= (station_addr_high_r & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
      end
    end
  end

  // filter byte mask words
  generate
    for (genvar w = 0; w < MASK_BITS / 32; w++) begin : g_mask
      always_ff @(posedge clk) begin
        if (rst) begin
          filter_byte_mask_r[w*32 +: 32] <= wfd_pkg::ZERO_RST;
        end else if (ce && acc_wr && avs_address == wfd_pkg::FILT_MASK0_OFS + 8'(4 * w)) begin
          filter_byte_mask_r[w*32 +: 32] <= (filter_byte_mask_r[w*32 +: 32] & ~be_mask) | (avs_writedata & be_mask);
        end
      end
    end
  endgenerate

  // wake control/status: enables and selects written, seen bits write-one-to-clear
  assign seen_clr = (acc_wr && avs_address == wfd_pkg::WAKE_CTRL_OFS) ?
                    (avs_writedata[7:4] & be_mask[7:4]) : 4'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ctrl_status_r <= 13'h0000;
    end else if (ce) begin
      if (acc_wr && avs_address == wfd_pkg::WAKE_CTRL_OFS) begin
        wake_ctrl_status_r[3:0] <= (wake_ctrl_status_r[3:0] & ~be_mask[3:0]) | (avs_writedata[3:0] & be_mask[3:0]);
        wake_ctrl_status_r[12:8] <= (wake_ctrl_status_r[12:8] & ~be_mask[12:8]) | (avs_writedata[12:8] & be_mask[12:8]);
      end
      // set beats clear
      wake_ctrl_status_r[7:4] <= (wake_ctrl_status_r[7:4] & ~seen_clr) | {hit_filt, hit_pat, hit_bcast, hit_exact};
    end
  end

  // filter configuration a and b
  always_ff @(posedge clk) begin
    if (rst) begin
      filter_config_a_r <= wfd_pkg::ZERO_RST;
      filter_config_b_r <= 16'h0000;
    end else if (ce) begin
      if (acc_wr && avs_address == wfd_pkg::FILT_CFG_A_OFS) begin
        filter_config_a_r <= ((filter_config_a_r & ~be_mask) | (avs_writedata & be_mask)) & 32'h8000_07FF;
        filter_config_a_r[wfd_pkg::FILT_TRIG_BIT] <= hit_filt ||
          (filter_config_a_r[wfd_pkg::FILT_TRIG_BIT] && !(avs_writedata[wfd_pkg::FILT_TRIG_BIT] && avs_byteenable[1]));
      end else if (hit_filt) begin
        filter_config_a_r[wfd_pkg::FILT_TRIG_BIT] <= 1'b1;
      end
      if (acc_wr && avs_address == wfd_pkg::FILT_CFG_B_OFS) begin
        filter_config_b_r <= (filter_config_b_r & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
      end
    end
  end

  // interrupt mask and source; cleared by soft reset too
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_r <= 1'b0;
      irq_src_r <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        irq_mask_r <= 1'b0;
        irq_src_r <= any_hit;
      end else begin
        if (acc_wr && avs_address == wfd_pkg::IRQ_MASK_OFS && avs_byteenable[1]) begin
          irq_mask_r <= avs_writedata[wfd_pkg::IRQ_WAKE_BIT];
        end
        irq_src_r <= any_hit || (irq_src_r && !(acc_wr && avs_address == wfd_pkg::IRQ_SRC_OFS &&
                     avs_byteenable[1] && avs_writedata[wfd_pkg::IRQ_WAKE_BIT]));
      end
    end
  end

  // frame position and destination address verdicts
  assign pos = rx_sof ? 11'h000 : pos_r;
  assign sta_byte = station[idx_r*8 +: 8];
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_r <= 11'h000;
      in_frame_r <= 1'b0;
      da_eq_r <= 1'b0;
      da_bc_r <= 1'b0;
      da_mc_r <= 1'b0;
    end else if (ce) begin
      if (soft_rst || rx_end) begin
        in_frame_r <= 1'b0;
      end else if (rx_valid && rx_sof) begin
        in_frame_r <= 1'b1;
      end
      if (rx_valid && (rx_sof || in_frame_r)) begin
        pos_r <= (pos == wfd_pkg::POS_MAX) ? pos : pos + 11'h001;
        if (pos <= wfd_pkg::DA_LAST) begin
          da_eq_r <= (rx_sof || da_eq_r) && rx_data == station[pos[2:0]*8 +: 8];
          da_bc_r <= (rx_sof || da_bc_r) && rx_data == wfd_pkg::ALL_ONES_BYTE;
          if (pos == 11'h000) begin
            da_mc_r <= rx_data[0];
          end
        end
      end
    end
  end

  // wake pattern search: sync run then sixteen station address copies
  always_ff @(posedge clk) begin
    if (rst) begin
      pat_r <= wfd_pkg::WFD_SEARCH;
      sync_r <= 3'h0;
      idx_r <= 3'h0;
      copies_r <= 5'h00;
    end else if (ce) begin
      if (soft_rst || (rx_valid && rx_sof)) begin
        pat_r <= wfd_pkg::WFD_SEARCH;
        sync_r <= 3'h0;
        idx_r <= 3'h0;
        copies_r <= 5'h00;
      end else if (rx_valid && in_frame_r && pos > wfd_pkg::SA_LAST) begin
        unique case (pat_r)
          wfd_pkg::WFD_SEARCH: begin
            if (rx_data == wfd_pkg::ALL_ONES_BYTE) begin
              if (sync_r + 3'h1 == wfd_pkg::SYNC_LEN) begin
                pat_r <= wfd_pkg::WFD_COPIES;
                idx_r <= 3'h0;
                copies_r <= 5'h00;
              end else begin
                sync_r <= sync_r + 3'h1;
              end
            end else begin
              sync_r <= 3'h0;
            end
          end
          wfd_pkg::WFD_COPIES: begin
            if (rx_data == sta_byte) begin
              idx_r <= (idx_r == wfd_pkg::ADDR_LAST_BYTE) ? 3'h0 : idx_r + 3'h1;
              if (idx_r == wfd_pkg::ADDR_LAST_BYTE) begin
                copies_r <= copies_r + 5'h01;
                if (copies_r + 5'h01 == wfd_pkg::COPY_COUNT) begin
                  pat_r <= wfd_pkg::WFD_FOUND;
                end
              end
            end else if (!(copies_r == 5'h00 && idx_r == 3'h0 && rx_data == wfd_pkg::ALL_ONES_BYTE)) begin
              pat_r <= wfd_pkg::WFD_SEARCH;
              sync_r <= (rx_data == wfd_pkg::ALL_ONES_BYTE) ? 3'h1 : 3'h0;
              idx_r <= 3'h0;
            end
          end
          wfd_pkg::WFD_FOUND: begin
            pat_r <= wfd_pkg::WFD_FOUND;
          end
          default: begin
            pat_r <= wfd_pkg::WFD_SEARCH;
          end
        endcase
      end
    end
  end

  // filter byte selection and crc
  assign rel = pos - 11'(filter_config_a_r[wfd_pkg::OFFSET_LSB +: 8]);
  assign sel_byte = rx_valid && (rx_sof || in_frame_r) &&
                    pos >= 11'(filter_config_a_r[wfd_pkg::OFFSET_LSB +: 8]) &&
                    rel < wfd_pkg::MASK_SPAN && filter_byte_mask_r[rel[6:0]];

  wfd_crc16 u_crc (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .init(rx_valid && rx_sof),
    .upd(sel_byte),
    .data(rx_data),
    .crc_r(crc_val)
  );

  // frame-end verdicts
  always_comb begin
    filt_addr_ok = 1'b0;
    if (da_bc_r) begin
      filt_addr_ok = filter_config_a_r[wfd_pkg::FILT_BCAST_BIT];
    end else if (da_mc_r) begin
      filt_addr_ok = filter_config_a_r[wfd_pkg::FILT_ANYMC_BIT] ||
                     (filter_config_a_r[wfd_pkg::FILT_ADDR_BIT] && da_eq_r);
    end else begin
      filt_addr_ok = !filter_config_a_r[wfd_pkg::FILT_ADDR_BIT] || da_eq_r;
    end
  end
  assign good_end = ce && rx_end && in_frame_r && rx_fcs_ok && rx_len_ok && !soft_rst;
  assign hit_exact = good_end && wake_ctrl_status_r[wfd_pkg::EXACT_EN_BIT] && da_eq_r;
  assign hit_bcast = good_end && wake_ctrl_status_r[wfd_pkg::BCAST_EN_BIT] && da_bc_r;
  assign hit_pat = good_end && wake_ctrl_status_r[wfd_pkg::PATTERN_EN_BIT] &&
                   pat_r == wfd_pkg::WFD_FOUND && (da_eq_r || da_bc_r);
  assign hit_filt = good_end && wake_ctrl_status_r[wfd_pkg::FILTER_EN_BIT] &&
                    filter_config_a_r[wfd_pkg::FILT_ENABLE_BIT] &&
                    crc_val == filter_config_b_r && filt_addr_ok;
  assign any_hit = hit_exact || hit_bcast || hit_pat || hit_filt;

  // pins
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_out_n <= 1'b1;
      power_event_out_n <= 1'b1;
      status_light_one <= 1'b0;
      status_light_two <= 1'b0;
    end else if (ce) begin
      irq_out_n <= !(irq_src_r && irq_mask_r);
      power_event_out_n <= !(|wake_ctrl_status_r[7:4]);
      status_light_one <= (wake_ctrl_status_r[wfd_pkg::LIGHT1_SEL_LSB +: 2] == wfd_pkg::LIGHT_SEL_PME) ?
                          !(|wake_ctrl_status_r[7:4]) : light_one_src;
      status_light_two <= (wake_ctrl_status_r[wfd_pkg::LIGHT2_SEL_LSB +: 2] == wfd_pkg::LIGHT_SEL_PME) ?
                          !(|wake_ctrl_status_r[7:4]) : light_two_src;
    end
  end
endmodule : wfd_top
`default_nettype wire

// ===== tb/wfd_sva.sv
// wfd_sva: port-level checks of the wake frame detector
// assumes binding into wfd_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module wfd_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic soft_rst,
  // bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // frame and pins
  input wire logic rx_end,
  input wire logic rx_fcs_ok,
  input wire logic rx_len_ok,
  input wire logic light_one_src,
  input wire logic irq_out_n,
  input wire logic power_event_out_n,
  input wire logic status_light_one
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic good_end;
  logic wr_done;
  assign good_end = rx_end && rx_fcs_ok && rx_len_ok;
  assign wr_done = avs_write && !avs_waitrequest;
  bus_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus request not answered");
  bus_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
  bus_idle_a:
    assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("answer without request");
  unmapped_zero_a:
    assert property (avs_read && !avs_waitrequest && avs_address > 8'h2C |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_cause_a:
    assert property ($fell(irq_out_n) |-> $past(good_end, 2) || $past(wr_done, 2)) else $error("irq without cause");
  irq_clear_a:
    assert property ($rose(irq_out_n) |-> $past(wr_done, 2) || $past(soft_rst, 2)) else $error("irq dropped alone");
  pme_cause_a:
    assert property ($fell(power_event_out_n) |-> $past(good_end, 2)) else $error("power event without frame");
  pme_hold_a:
    assert property ($rose(power_event_out_n) |-> $past(wr_done, 2)) else $error("power event dropped alone");
  light_sel_a:
    assert property (status_light_one != $past(light_one_src) |-> status_light_one == power_event_out_n)
    else $error("light one neither source nor power event");
  cover property (good_end ##2 !irq_out_n);
  cover property (wr_done && avs_address == 8'h0C);
  cover property ($rose(power_event_out_n));
endmodule : wfd_sva
bind wfd_top wfd_sva chk (.clk(clk), .rst(rst), .ce(ce), .soft_rst(soft_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok), .light_one_src(light_one_src),
  .irq_out_n(irq_out_n), .power_event_out_n(power_event_out_n), .status_light_one(status_light_one));
`default_nettype wire

// ===== tb/wfd_station.sv
// wfd_station: remote station model sending received frames
// assumes frame bytes are loaded into fbuf before send
`timescale 1ns/1ps
`default_nettype none
module wfd_station (
  // clock
  input wire logic clk,
  // receive stream
  output logic rx_valid,
  output logic rx_sof,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_fcs_ok,
  output logic rx_len_ok
);
  logic [7:0] fbuf [0:255];
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'hA5;
    rx_end = 1'b0;
    rx_fcs_ok = 1'b0;
    rx_len_ok = 1'b0;
  end
  // gap idle cycles after each byte, idle data is the inverse of the last byte
  task automatic send(input int n, input logic fcs, input logic len, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= fbuf[i];
      repeat (gap) begin
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_data <= ~fbuf[i];
      end
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_data <= ~fbuf[n-1];
    rx_end <= 1'b1;
    rx_fcs_ok <= fcs;
    rx_len_ok <= len;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_fcs_ok <= ~fcs;
    rx_len_ok <= ~len;
  endtask : send
endmodule : wfd_station
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench of the wake frame detector
// assumes wfd_top, the station model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic clk;
  logic rst;
  logic soft_rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_valid;
  logic rx_sof;
  logic [7:0] rx_data;
  logic rx_end;
  logic rx_fcs_ok;
  logic rx_len_ok;
  logic light_one_src;
  logic irq_out_n;
  logic power_event_out_n;
  logic status_light_one;
  logic status_light_two;
  logic [15:0] crc;
  int fails = 0;
  int comparisons = 0;
  logic [7:0] fda [6] = '{8'h02, 8'h02, 8'h01, 8'hFF, 8'hFF, 8'h00};
  logic [2:0] fcf [6] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h4, 3'h4};
  logic fex [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  wfd_top dut (.clk(clk), .rst(rst), .ce(1'b1), .soft_rst(soft_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok),
    .light_one_src(light_one_src), .light_two_src(light_one_src), .irq_out_n(irq_out_n),
    .power_event_out_n(power_event_out_n), .status_light_one(status_light_one),
    .status_light_two(status_light_two));
  wfd_station st (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data), .rx_end(rx_end),
    .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 40) begin
      fails++;
      print_verdict();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [7:0] f;
    f[0] = c[15] ^ d[0];
    for (int i = 1; i < 8; i++) f[i] = c[15-i] ^ f[i-1] ^ d[i];
    return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4],
      f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
  endfunction : crc_step
  // da 00 selects the station address, else all six bytes equal da
  task automatic mk(input logic [7:0] da, input int n);
    for (int i = 0; i < n; i++) st.fbuf[i] = (i < 6) ? ((da == 8'h00) ? 8'(17 * i) : da) : 8'(i + 48);
  endtask : mk
  // sync, 3 copies, break, sync, 16 copies; brk spoils the last copy
  task automatic pat(input logic [7:0] da, input logic brk);
    mk(da, 160);
    for (int i = 0; i < 6; i++) begin
      st.fbuf[14 + i] = 8'hFF;
      st.fbuf[39 + i] = 8'hFF;
    end
    for (int i = 0; i < 96; i++) begin
      st.fbuf[45 + i] = 8'(17 * (i % 6));
      if (i < 18) st.fbuf[20 + i] = 8'(17 * (i % 6));
    end
    if (brk) st.fbuf[135] = 8'h77;
    st.send(160, 1'b1, 1'b1, 0);
  endtask : pat
  // checks pins and flags after a frame, then clears the flags
  task automatic hit(input logic [31:0] ctl, input logic w);
    repeat (3) @(posedge clk);
    `CHK(irq_out_n, !w)
    `CHK(power_event_out_n, !w)
    rd(8'h2C, w ? 32'h0000_0100 : 32'h0);
    rd(8'h0C, ctl);
    wr(8'h2C, 32'h0000_0100);
    wr(8'h0C, ctl);
  endtask : hit
  initial begin
    rst = 1'b1;
    soft_rst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    light_one_src = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 64; a += 4) rd(8'(a), 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'h0000_1100);
    wr(8'h04, 32'h0000_3322);
    wr(8'h08, 32'h0000_5544);
    wr(8'h28, 32'h0000_0100);
    wr(8'h0C, 32'h1);
    mk(8'h00, 64);
    st.send(64, 1'b1, 1'b1, 0);
    hit(32'h11, 1'b1);
    st.send(64, 1'b0, 1'b1, 0);
    hit(32'h01, 1'b0);
    st.send(64, 1'b1, 1'b0, 3);
    hit(32'h01, 1'b0);
    mk(8'h02, 64);
    st.send(64, 1'b1, 1'b1, 0);
    hit(32'h01, 1'b0);
    $display("test exact address done");
    wr(8'h0C, 32'h2);
    mk(8'hFF, 64);
    st.send(64, 1'b1, 1'b1, 1);
    hit(32'h22, 1'b1);
    mk(8'h00, 64);
    st.send(64, 1'b1, 1'b1, 0);
    hit(32'h02, 1'b0);
    $display("test broadcast done");
    wr(8'h0C, 32'h4);
    pat(8'h02, 1'b0);
    hit(32'h04, 1'b0);
    pat(8'h00, 1'b1);
    hit(32'h04, 1'b0);
    pat(8'h00, 1'b0);
    hit(32'h44, 1'b1);
    pat(8'hFF, 1'b0);
    hit(32'h44, 1'b1);
    $display("test wake pattern done");
    wr(8'h0C, 32'h8);
    crc = crc_step(crc_step(16'hFFFF, 8'h3E), 8'h40);
    wr(8'h18, 32'h0000_0005);
    wr(8'h14, {16'h0, crc});
    for (int c = 0; c < 6; c++) begin
      wr(8'h10, 32'h8000_080E | {21'h0, fcf[c], 8'h0});
      mk(fda[c], 64);
      st.send(64, 1'b1, 1'b1, c % 2);
      rd(8'h10, 32'h8000_000E | {21'h0, fcf[c], 8'h0} | {20'h0, fex[c], 11'h0});
      hit(fex[c] ? 32'h88 : 32'h08, fex[c]);
    end
    $display("test filter done");
    light_one_src <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(status_light_one, 1'b1)
    `CHK(status_light_two, 1'b1)
    wr(8'h0C, 32'h1A01);
    mk(8'h00, 64);
    st.send(64, 1'b1, 1'b1, 0);
    repeat (3) @(posedge clk);
    `CHK(status_light_one, 1'b0)
    `CHK(status_light_two, 1'b0)
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rd(8'h0C, 32'h1A11);
    rd(8'h00, 32'h0000_1100);
    rd(8'h28, 32'h0);
    wr(8'h0C, 32'h1A11);
    repeat (3) @(posedge clk);
    `CHK(power_event_out_n, 1'b1)
    `CHK(status_light_one, 1'b1)
    `CHK(status_light_two, 1'b1)
    $display("test power event done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
